/* sbf_defines.svh */
/*
 * Constants for the synchronous flow-through burst SRAM: array geometry,
 * burst counter width and reset values.
 * Assumes it is included by bare name from the package and the modules.
 */
// Notes on behaviour
// - a two-bit burst counter loads the first address and advances through the burst.
// - every synchronous input is captured on the rising clock edge.
// - burst order select high means interleaved order, low means linear order.
// - a burst may start from either the processor or controller address strobe.
// - later burst addresses come from the counter, advanced only by burst advance.
// - address and chip selects are registered only while an address strobe is active.
// - output drive enable and sleep act without the clock.
// - a four-beat burst runs one cycle for the first beat, then one each.
// - array is 256K words of 36 bits on one shared data bus.
// - the two lowest address bits are the counter start value.
// - strobes are active low; address taken when a strobe low and chip selected.
// - all-bytes write low writes every lane, whatever the lane selects show.
// - a lane select writes its lane only with the byte-write qualifier asserted.
`ifndef SBF_DEFINES_SVH
`define SBF_DEFINES_SVH

`define SBF_ADDR_W   18
`define SBF_DEPTH    262144
`define SBF_DATA_W   36
`define SBF_LANES    4
`define SBF_LANE_W   9
`define SBF_CNT_W    2
`define SBF_UPPER_W  16
`define SBF_CNT_ZERO 2'h0
`define SBF_CNT_ONE  2'h1
`define SBF_UPPER_ZERO 16'h0000
`define SBF_DATA_ZERO  36'h0_0000_0000

`endif

/* sbf_pkg.sv */
/*
 * Types shared by the burst SRAM modules: access mode and the packed
 * state and sampled-control carriers.
 * Assumes sbf_defines.svh is on the include path.
 */
`include "sbf_defines.svh"

package sbf_pkg;

  // what the last cycle did: idle, or a read or write beat of the burst
  typedef enum logic [1:0] {
    SBF_IDLE  = 2'b00,
    SBF_READ  = 2'b01,
    SBF_WRITE = 2'b10
  } sbf_mode_e;

  // synchronous control pins as sampled at one edge
  typedef struct packed {
    logic                    proc_strobe;   // processor strobe asserted
    logic                    ctrl_strobe;   // controller strobe asserted
    logic                    advance;       // burst advance asserted
    logic                    selected;      // all chip selects active
    logic                    pipe_sel;      // pipelined select alone
    logic [`SBF_LANES-1:0]   lane_wr;       // decoded lane writes
  } sbf_ctl_s;

  // whole state of the controller
  typedef struct packed {
    sbf_mode_e               mode;
    logic [`SBF_UPPER_W-1:0] upper;         // registered address above the counter
    logic [`SBF_CNT_W-1:0]   start;         // counter start value
    logic [`SBF_CNT_W-1:0]   beat;          // beat index within the burst
    logic [`SBF_DATA_W-1:0]  rd_data;       // flow-through output word
  } sbf_state_s;

endpackage : sbf_pkg

/* sbf_byte_wr.sv */
/*
 * Byte-lane write decoder for the burst SRAM.
 * Assumes active-low pins already sampled on the current edge.
 */
`include "sbf_defines.svh"
module sbf_byte_wr
  import sbf_pkg::*;
(
  input  wire logic [`SBF_LANES-1:0] byte_lane_write_select_n,
  input  wire logic                  byte_write_qualifier_n,
  input  wire logic                  all_bytes_write_n,
  output logic      [`SBF_LANES-1:0] lane_wr
);

  // global write overrides lane selects; a lane needs its qualifier
  always_comb begin
    if (!all_bytes_write_n) begin
      lane_wr = '1;
    end else if (!byte_write_qualifier_n) begin
      lane_wr = ~byte_lane_write_select_n;
    end else begin
      lane_wr = '0;
    end
  end

endmodule : sbf_byte_wr

/* sbf_sram.sv */
/*
 * Synchronous flow-through burst SRAM: 256K x 36 array, address strobes,
 * two-bit burst counter, byte-lane writes and async output drive control.
 * Assumes all synchronous pins are stable around the core_clk rising edge;
 * the shared data pin is split into input, output and active-low enable.
 */
`include "sbf_defines.svh"
module sbf_sram
  import sbf_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic [`SBF_ADDR_W-1:0] addr,
  input  wire logic [`SBF_DATA_W-1:0] dq_in,
  output logic      [`SBF_DATA_W-1:0] dq_out,
  output logic                        dq_oe_n,
  input  wire logic                   processor_addr_strobe_n,
  input  wire logic                   controller_addr_strobe_n,
  input  wire logic                   burst_advance_n,
  input  wire logic                   pipelined_chip_select_n,
  input  wire logic                   depth_chip_select_hi,
  input  wire logic                   depth_chip_select_lo_n,
  input  wire logic                   all_bytes_write_n,
  input  wire logic                   byte_write_qualifier_n,
  input  wire logic [`SBF_LANES-1:0]  byte_lane_write_select_n,
  input  wire logic                   burst_order_sel,
  input  wire logic                   output_enable_n,
  input  wire logic                   sleep_pin
);

  sbf_state_s              st_q;
  sbf_state_s              st_d;
  sbf_ctl_s                ctl;
  logic [`SBF_LANES-1:0]   lane_wr;
  logic [`SBF_ADDR_W-1:0]  eff_addr;
  logic                    do_write;
  logic [`SBF_DATA_W-1:0]  mem [`SBF_DEPTH];

  // burst address low bits from start value and beat index
  function automatic logic [`SBF_CNT_W-1:0] burst_low(
    input logic                  interleaved,
    input logic [`SBF_CNT_W-1:0] start,
    input logic [`SBF_CNT_W-1:0] beat
  );
    if (interleaved) begin
      burst_low = start ^ beat;
    end else begin
      burst_low = start + beat;                          // wraps modulo four
    end
  endfunction : burst_low

  sbf_byte_wr u_byte_wr (
    .byte_lane_write_select_n (byte_lane_write_select_n),
    .byte_write_qualifier_n   (byte_write_qualifier_n),
    .all_bytes_write_n        (all_bytes_write_n),
    .lane_wr                  (lane_wr)
  );

  // decode the pins seen at this edge; sleep blocks every new cycle
  always_comb begin
    ctl.proc_strobe = !processor_addr_strobe_n && !sleep_pin;
    ctl.ctrl_strobe = !controller_addr_strobe_n && !sleep_pin;
    ctl.advance     = !burst_advance_n && !sleep_pin;
    ctl.pipe_sel    = !pipelined_chip_select_n;
    ctl.selected    = !pipelined_chip_select_n && depth_chip_select_hi
                      && !depth_chip_select_lo_n;
    ctl.lane_wr     = sleep_pin ? '0 : lane_wr;
  end

  // next state: strobe cycles load address, otherwise the counter runs
  always_comb begin
    st_d     = st_q;
    eff_addr = {st_q.upper, burst_low(burst_order_sel, st_q.start, st_q.beat)};
    do_write = 1'b0;
    // processor strobe counts only with the pipelined select active
    if ((ctl.proc_strobe && ctl.pipe_sel) || ctl.ctrl_strobe) begin
      if (ctl.selected) begin
        st_d.upper = addr[`SBF_ADDR_W-1:`SBF_CNT_W];
        st_d.start = addr[`SBF_CNT_W-1:0];
        st_d.beat  = `SBF_CNT_ZERO;
        eff_addr   = addr;
        // processor strobe cycle never writes: data follows next cycle
        if (!ctl.proc_strobe && (|ctl.lane_wr)) begin
          st_d.mode = SBF_WRITE;
          do_write  = 1'b1;
        end else begin
          st_d.mode = SBF_READ;
        end
      end else begin
        st_d.mode = SBF_IDLE;                            // deselect ends any burst
      end
    end else if (st_q.mode != SBF_IDLE) begin
      if (ctl.advance) begin
        st_d.beat = st_q.beat + `SBF_CNT_ONE;
        eff_addr  = {st_q.upper, burst_low(burst_order_sel, st_q.start, st_d.beat)};
      end
      // a continuation cycle may turn a read burst into writes
      if (|ctl.lane_wr) begin
        st_d.mode = SBF_WRITE;
        do_write  = 1'b1;
      end else begin
        st_d.mode = SBF_READ;
      end
    end
    // flow-through: word for this address goes out right after the edge
    if (!do_write && st_d.mode == SBF_READ) begin
      st_d.rd_data = mem[eff_addr];
    end
  end

  // single state register; all synchronous pins are captured at this edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q.mode    <= SBF_IDLE;
      st_q.upper   <= `SBF_UPPER_ZERO;
      st_q.start   <= `SBF_CNT_ZERO;
      st_q.beat    <= `SBF_CNT_ZERO;
      st_q.rd_data <= `SBF_DATA_ZERO;
    end else begin
      st_q <= st_d;
    end
  end

  // array write, lane by lane; the array itself has no reset
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < `SBF_LANES; i++) begin
      if (do_write && ctl.lane_wr[i]) begin
        mem[eff_addr][i*`SBF_LANE_W +: `SBF_LANE_W] <=
          dq_in[i*`SBF_LANE_W +: `SBF_LANE_W];
      end
    end
  end

  // output drive follows enable and sleep with no clock involved
  assign dq_out  = st_q.rd_data;
  assign dq_oe_n = !(st_q.mode == SBF_READ && !output_enable_n && !sleep_pin);

endmodule : sbf_sram

/* sbf_bus_end.sv */
/* sbf_bus_end: the shared data wire as the bus master sees it.
   Assumes the master raises drv only on beats where it writes. */
module sbf_bus_end
  import sbf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic [35:0] dq_out,
  input  wire logic        dq_oe_n,
  input  wire logic        drv,
  input  wire logic [35:0] m_data,
  output logic      [35:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] last_q = '0;
  // an undriven wire flips each cycle so a stale word never passes as data
  assign dq_in = !dq_oe_n ? dq_out : (drv ? m_data : ~last_q);
  always_ff @(posedge core_clk) last_q <= dq_in;
endmodule : sbf_bus_end

/* sbf_sram_monitor.sv */
/* sbf_sram_monitor: timing checks on the burst SRAM pins.
   Assumes it is bound to sbf_sram and sees only its ports. */
module sbf_sram_monitor
  import sbf_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic [35:0] dq_out,
  input wire logic        dq_oe_n,
  input wire logic        processor_addr_strobe_n,
  input wire logic        controller_addr_strobe_n,
  input wire logic        burst_advance_n,
  input wire logic        pipelined_chip_select_n,
  input wire logic        depth_chip_select_hi,
  input wire logic        depth_chip_select_lo_n,
  input wire logic        all_bytes_write_n,
  input wire logic        byte_write_qualifier_n,
  input wire logic        output_enable_n,
  input wire logic        sleep_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel, nowr, rd, hold, xoe;
  // lane selects left out: nowr is stricter, so no false firing
  assign sel = !pipelined_chip_select_n && depth_chip_select_hi && !depth_chip_select_lo_n;
  assign nowr = all_bytes_write_n && byte_write_qualifier_n && !sleep_pin;
  assign rd = !controller_addr_strobe_n && sel && nowr;
  assign hold = processor_addr_strobe_n && controller_addr_strobe_n && nowr;
  assign xoe = output_enable_n || sleep_pin;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_oe_off: assert property (output_enable_n |-> dq_oe_n)
    else $error("data driven with output enable off");
  a_sleep_off: assert property (sleep_pin |-> dq_oe_n)
    else $error("data driven in sleep");
  a_ctrl_read: assert property (rd |=> dq_oe_n == xoe)
    else $error("controller strobe read not driven");
  a_proc_read: assert property (!processor_addr_strobe_n && sel && !sleep_pin |=> dq_oe_n == xoe)
    else $error("processor strobe read not driven");
  a_global_write: assert property (!controller_addr_strobe_n && processor_addr_strobe_n
    && sel && !all_bytes_write_n && !sleep_pin |=> dq_oe_n)
    else $error("write cycle drives data");
  a_unsel_idle: assert property (!controller_addr_strobe_n && !sel && !sleep_pin |=> dq_oe_n)
    else $error("deselect still drives");
  a_hold_word: assert property (!dq_oe_n && hold && burst_advance_n |=> $stable(dq_out))
    else $error("word moved without advance");
  a_burst_run: assert property (rd ##1 (hold && !burst_advance_n)[*3] |=> dq_oe_n == xoe)
    else $error("burst beats not all driven");
endmodule : sbf_sram_monitor

bind sbf_sram sbf_sram_monitor u_mon (.core_clk, .resetn, .dq_out, .dq_oe_n,
  .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
  .pipelined_chip_select_n, .depth_chip_select_hi, .depth_chip_select_lo_n,
  .all_bytes_write_n, .byte_write_qualifier_n, .output_enable_n, .sleep_pin);

/* sbf_sram_tb.sv */
/* sbf_sram_tb: burst write, read, byte lane and strobe tests.
   Assumes sbf_bus_end resolves the shared data wire. */
module sbf_sram_tb;
  import sbf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, resetn, drv, burst_order_sel, output_enable_n, sleep_pin, dq_oe_n;
  logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
  logic pipelined_chip_select_n, depth_chip_select_hi, depth_chip_select_lo_n;
  logic all_bytes_write_n, byte_write_qualifier_n;
  logic [3:0]  byte_lane_write_select_n;
  logic [17:0] addr;
  logic [35:0] dq_in, dq_out, m_data;
  logic [35:0] sh [4];
  int          failures, comparisons;
  sbf_sram u_dut (.core_clk, .resetn, .addr, .dq_in, .dq_out, .dq_oe_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
    .pipelined_chip_select_n, .depth_chip_select_hi, .depth_chip_select_lo_n,
    .all_bytes_write_n, .byte_write_qualifier_n, .byte_lane_write_select_n,
    .burst_order_sel, .output_enable_n, .sleep_pin);
  sbf_bus_end u_bus (.core_clk, .dq_out, .dq_oe_n, .drv, .m_data, .dq_in);
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  // expected beat address, worked out apart from the design
  function automatic logic [1:0] nxt(input logic [1:0] s, b, input logic il);
    return il ? s ^ b : s + b;
  endfunction : nxt
  // one bus cycle: pins set after a falling edge, held over the rising one;
  // outputs are switched off on write beats so the data wire has one driver
  task automatic cyc(input logic ps, cs, nx, ab, bq, input logic [3:0] ls,
                     input logic [17:0] a, input logic [35:0] d);
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = {ps, cs, nx};
    {all_bytes_write_n, byte_write_qualifier_n, byte_lane_write_select_n} = {ab, bq, ls};
    {addr, m_data, drv} = {a, d, !ab || !bq};
    output_enable_n = !ab || !bq;
    @(negedge core_clk);
  endtask : cyc
  task automatic chk_word(input string n, input logic [35:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string n, input logic e, g);
    chk_word(n, {35'h0, e}, {35'h0, g});
  endtask : chk_bit
  task automatic summarize;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (2000) @(negedge core_clk);
    failures++;
    summarize();
  end
  initial begin
    {pipelined_chip_select_n, depth_chip_select_lo_n, depth_chip_select_hi} = 3'h1;
    {resetn, burst_order_sel, output_enable_n, sleep_pin} = 4'h0;
    cyc(1, 1, 1, 1, 1, 4'hf, 18'h0, 36'h0);
    repeat (2) @(negedge core_clk);
    resetn = 1;
    // write a burst from start 1, read back from start 3 in the other order
    for (int il = 0; il < 2; il++) begin
      burst_order_sel = il[0];
      for (int b = 0; b < 4; b++) begin
        sh[nxt(2'h1, b[1:0], il[0])] = 36'h5_a0c3_1100 + 36'(il * 4 + b);
        cyc(1, b != 0, b == 0, 0, 1, 4'hf, b == 0 ? 18'h2_4c01 : 18'h3_ff02,
            sh[nxt(2'h1, b[1:0], il[0])]);
      end
      burst_order_sel = !il[0];
      for (int b = 0; b < 4; b++) begin
        cyc(1, b != 0, b == 0, 1, 1, 4'hf, 18'h2_4c03, 36'h0);
        chk_word("beat", sh[nxt(2'h3, b[1:0], !il[0])], dq_out);
      end
    end
    cyc(1, 0, 1, 1, 0, 4'ha, 18'h2_4c00, 36'h1_2345_6789);
    sh[0] = (sh[0] & 36'hf_f803_fe00) | 36'h0_0344_0189;
    cyc(1, 1, 1, 1, 1, 4'h0, 18'h0, 36'h0);
    chk_word("lanes", sh[0], dq_out);
    cyc(0, 1, 1, 0, 1, 4'hf, 18'h2_4c01, 36'h0);
    chk_word("proc", sh[1], dq_out);
    cyc(1, 1, 1, 0, 1, 4'hf, 18'h0, 36'h0_dead_beef);
    pipelined_chip_select_n = 1;
    cyc(0, 1, 1, 1, 1, 4'hf, 18'h2_4c02, 36'h0);
    chk_word("pipe_sel", 36'h0_dead_beef, dq_out);
    {pipelined_chip_select_n, depth_chip_select_hi} = 2'h0;
    cyc(1, 0, 1, 1, 1, 4'hf, 18'h2_4c02, 36'h0);
    chk_bit("unsel", 1, dq_oe_n);
    depth_chip_select_hi = 1;
    cyc(1, 0, 1, 1, 1, 4'hf, 18'h2_4c01, 36'h0);
    cyc(1, 1, 1, 1, 1, 4'hf, 18'h0, 36'h0);
    chk_word("hold", 36'h0_dead_beef, dq_out);
    output_enable_n = 1;
    #5 chk_bit("oe", 1, dq_oe_n);
    @(negedge core_clk);
    // sleep held over an edge: the strobe is ignored and nothing is driven
    sleep_pin = 1;
    cyc(1, 0, 1, 1, 1, 4'hf, 18'h2_4c02, 36'h0);
    chk_bit("sleep", 1, dq_oe_n);
    chk_word("sleep_word", 36'h0_dead_beef, dq_out);
    sleep_pin = 0;
    #5 chk_bit("drive", 0, dq_oe_n);
    summarize();
  end
endmodule : sbf_sram_tb
